// ===== uic_top.sv
// Universal input 3: digital input, edge interrupt, counters and measurement
// Assumes an Avalon-MM master on core_clk and an asynchronous pin on in_pin
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module uic_top
#(
    parameter longint TICK_CYCLES = uic_pkg::gate_100ms_cyc,
    parameter int     CW          = uic_pkg::count_width
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic        in_pin,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]   config_reg;
    logic [CW-1:0] start_cmp;
    logic [1:0]    control;
    logic [CW-1:0] count;
    logic [CW-1:0] measure;
    logic [2:0]    status;
    logic [2:0]    mask;
    logic          pending;
    logic [7:0]    pend_cnt;
    logic          ack_done;
    logic [31:0]   rdata;
    logic          load_prev;

    uic_pkg::mode_e mode;
    logic           dir_down;
    logic           edge_fall;
    logic           cnt_irq_en;
    logic [1:0]     gate_sel;

    assign mode       = uic_pkg::mode_e'(config_reg[uic_pkg::cfg_mode_lsb +: 3]);
    assign dir_down   = config_reg[uic_pkg::cfg_down_bit];
    assign edge_fall  = config_reg[uic_pkg::cfg_fall_bit];
    assign cnt_irq_en = config_reg[uic_pkg::cfg_irq_en_bit];
    assign gate_sel   = config_reg[uic_pkg::cfg_gate_lsb +: 2];

    ////////////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic sel_edge;

    uic_sync u_sync
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (in_pin),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    assign sel_edge = edge_fall ? pin_fall : pin_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wr_cfg;
    logic wr_cmp;
    logic wr_ctl;
    logic wr_status;
    logic wr_mask;
    logic wr_pend;
    logic [31:0] wmask;
    logic        rd_done;
    logic        rd_capture;

    // Writes never wait; a read waits one cycle for its registered data
    assign rd_capture      = avs_read && !rd_done;
    assign avs_waitrequest = rd_capture;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_cfg    = avs_write && (avs_address == uic_pkg::addr_config);
    assign wr_cmp    = avs_write && (avs_address == uic_pkg::addr_start_cmp);
    assign wr_ctl    = avs_write && (avs_address == uic_pkg::addr_control);
    assign wr_status = avs_write && (avs_address == uic_pkg::addr_status);
    assign wr_mask   = avs_write && (avs_address == uic_pkg::addr_mask);
    assign wr_pend   = avs_write && (avs_address == uic_pkg::addr_pending) && avs_writedata[0] && avs_byteenable[0];

    always_comb
    begin
        rdata = 32'h0000_0000;
        if (avs_address == uic_pkg::addr_config)
            rdata = config_reg;
        else if (avs_address == uic_pkg::addr_start_cmp)
            rdata = 32'(start_cmp);
        else if (avs_address == uic_pkg::addr_control)
            rdata = 32'(control);
        else if (avs_address == uic_pkg::addr_count)
            rdata = 32'(count);
        else if (avs_address == uic_pkg::addr_measure)
            rdata = 32'(measure);
        else if (avs_address == uic_pkg::addr_pin)
            rdata = {31'h0000_0000, pin_level};
        else if (avs_address == uic_pkg::addr_status)
            rdata = 32'(status);
        else if (avs_address == uic_pkg::addr_mask)
            rdata = 32'(mask);
        else if (avs_address == uic_pkg::addr_info_a)
            rdata = {16'h0000, uic_pkg::module_address};
        else if (avs_address == uic_pkg::addr_info_b)
            rdata = {16'h0000, uic_pkg::input_number, 8'h00};
        else if (avs_address == uic_pkg::addr_info_c)
            rdata = {16'h0000, uic_pkg::info_c_value};
        else if (avs_address == uic_pkg::addr_pending)
            rdata = {16'h0000, pend_cnt, 7'h00, pending};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answer
    // One wait state per read so the registered data stands at the accepting edge
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_done      <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            rd_done <= rd_capture;
            if (rd_capture)
                avs_readdata <= rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            config_reg <= uic_pkg::config_reset;
            start_cmp  <= '0;
            control    <= 2'h0;
            mask       <= 3'h0;
        end
        else
        begin
            if (wr_cfg)
                config_reg <= (config_reg & ~wmask) | (avs_writedata & wmask);
            if (wr_cmp)
                start_cmp <= CW'((32'(start_cmp) & ~wmask) | (avs_writedata & wmask));
            if (wr_ctl && avs_byteenable[0])
                control <= avs_writedata[1:0];
            if (wr_mask && avs_byteenable[0])
                mask <= avs_writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counting and measurement
    logic          enabled;
    logic          load_rise;
    logic          gate_end;
    logic          cnt_hit;
    logic [CW-1:0] acc;
    logic          period_armed;
    logic          cnt_max;

    assign enabled   = control[uic_pkg::ctl_enable_bit];
    assign load_rise = control[uic_pkg::ctl_load_bit] & ~load_prev;
    assign cnt_max   = (count == {CW{1'b1}});

    uic_gate_timer #(.TICK_CYCLES(TICK_CYCLES)) u_gate
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (enabled && (mode == uic_pkg::mode_frequency)),
        .gate_sel (gate_sel),
        .gate_end (gate_end)
    );

    // Up hits at compare; down fires when passing 1 to 0
    assign cnt_hit = (mode == uic_pkg::mode_counter) && enabled && sel_edge && cnt_irq_en &&
                     (dir_down ? (count == CW'(1)) : (count + CW'(1) == start_cmp));

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count        <= '0;
            measure      <= '0;
            acc          <= '0;
            load_prev    <= 1'b0;
            period_armed <= 1'b0;
        end
        else
        begin
            load_prev <= control[uic_pkg::ctl_load_bit];
            case (mode)
                uic_pkg::mode_counter:
                begin
                    if (load_rise)
                        count <= dir_down ? start_cmp : '0;
                    else if (enabled && sel_edge)
                    begin
                        if (dir_down)
                            count <= (count == '0) ? count : count - CW'(1);
                        else if (!cnt_max && !(cnt_irq_en && count == start_cmp && start_cmp != '0))
                            count <= count + CW'(1);
                    end
                end
                uic_pkg::mode_frequency:
                begin
                    if (gate_end)
                    begin
                        measure <= acc + CW'(pin_rise);
                        acc     <= '0;
                    end
                    else if (enabled && pin_rise)
                        acc <= acc + CW'(1);
                end
                uic_pkg::mode_period:
                begin
                    // Clock cycles between rising edges; saturates on slow inputs
                    if (enabled && pin_rise)
                    begin
                        if (period_armed)
                            measure <= acc;
                        period_armed <= 1'b1;
                        acc          <= CW'(1);
                    end
                    else if (enabled && acc != {CW{1'b1}})
                        acc <= acc + CW'(1);
                end
                uic_pkg::mode_gate:
                begin
                    // Counts clock cycles while the pin holds the gate open
                    if (load_rise)
                        count <= '0;
                    else if (enabled && pin_level && !cnt_max)
                        count <= count + CW'(1);
                end
                default:
                begin
                    acc          <= '0;
                    period_armed <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt events
    logic edge_hit;
    logic any_event;
    logic [2:0] event_bits;
    logic overrun;
    logic       pend_inc;
    logic       pend_dec;
    logic [7:0] next_pend_cnt;

    assign edge_hit   = (mode == uic_pkg::mode_edge_irq) && sel_edge;
    assign any_event  = edge_hit | cnt_hit;
    // Host acks an event via the pending register; unacked events queue up
    assign overrun    = any_event && (pend_cnt == 8'hff) && !wr_pend;
    assign event_bits = {overrun, cnt_hit, edge_hit};
    assign ack_done   = wr_pend && pending;
    assign pend_inc   = any_event && !overrun;
    assign pend_dec   = ack_done && (pend_cnt != 8'h00);
    assign next_pend_cnt = (pend_inc && !ack_done) ? pend_cnt + 8'd1 :
                           (!pend_inc && pend_dec) ? pend_cnt - 8'd1 : pend_cnt;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            status <= 3'h0;
        else
        begin
            // Set wins over a simultaneous clear
            status <= (wr_status ? (status & ~avs_writedata[2:0]) : status) | event_bits;
        end
    end

    // Pending follows the next count, so no stale request outlives the last ack
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_cnt <= 8'h00;
            pending  <= 1'b0;
        end
        else
        begin
            pend_cnt <= next_pend_cnt;
            pending  <= (next_pend_cnt != 8'h00);
        end
    end

    assign irq = |(status & mask);
endmodule // uic_top
`default_nettype wire

// ===== uic_pkg.sv
// Constants, register map and modes of the universal input 3 counter block
// Behaviour
// - Six modes: plain, edge interrupt, counter, frequency, period, gate counter; plain after reset.
// - Counter direction up or down; up by default.
// - Counter counts on rising or falling edge; rising by default.
// - Counter interrupt option, at compare value up or zero passage down; off by default.
// - Frequency gate time 0.1 s, 1 s or 10 s; 1 s by default.
// - Period and 24 bit gate counter modes need only the mode selection; here both also need the control enable bit.
// - Deactivated input behaves as an ordinary digital input.
// - Deactivated input state is shown only on direct host read, not in images.
// - Edge interrupt mode interrupts on every configured edge.
// - Enabled counter interrupts at compare value up, or passing zero down.
// - First info word carries module start address 272 (0x0110).
// - Second info word byte 8 holds input number; byte 9 meaningless.
// - Third info word always reads 0x0000.
// - Counter 3 is 24 bits wide and presented as 24 bits.
// - Edge interrupt mode defaults to rising edge.
package uic_pkg;
    typedef enum logic [2:0] {
        mode_plain,
        mode_edge_irq,
        mode_counter,
        mode_frequency,
        mode_period,
        mode_gate
    } mode_e;

    localparam logic [7:0]  addr_config     = 8'h00;
    localparam logic [7:0]  addr_start_cmp  = 8'h04;
    localparam logic [7:0]  addr_control    = 8'h08;
    localparam logic [7:0]  addr_count      = 8'h0c;
    localparam logic [7:0]  addr_measure    = 8'h10;
    localparam logic [7:0]  addr_pin        = 8'h14;
    localparam logic [7:0]  addr_status     = 8'h18;
    localparam logic [7:0]  addr_mask       = 8'h1c;
    localparam logic [7:0]  addr_info_a     = 8'h20;
    localparam logic [7:0]  addr_info_b     = 8'h24;
    localparam logic [7:0]  addr_info_c     = 8'h28;
    localparam logic [7:0]  addr_pending    = 8'h2c;

    // Config fields
    localparam int          cfg_mode_lsb    = 0;
    localparam int          cfg_down_bit    = 4;
    localparam int          cfg_fall_bit    = 5;
    localparam int          cfg_irq_en_bit  = 6;
    localparam int          cfg_gate_lsb    = 8;
    localparam logic [1:0]  gate_100ms      = 2'h0;
    localparam logic [1:0]  gate_1s         = 2'h1;
    localparam logic [1:0]  gate_10s        = 2'h2;
    // Reset: plain, up, rising, irq off, gate 1 s
    localparam logic [31:0] config_reset    = 32'h0000_0100;

    // Control fields
    localparam int          ctl_enable_bit  = 0;
    localparam int          ctl_load_bit    = 1;

    // Status bits
    localparam int          st_edge_bit     = 0;
    localparam int          st_count_bit    = 1;
    localparam int          st_overrun_bit  = 2;

    localparam int          count_width     = 24;
    localparam logic [15:0] module_address  = 16'h0110;
    localparam logic [7:0]  input_number    = 8'h03;
    localparam logic [15:0] info_c_value    = 16'h0000;

    localparam longint      clk_hz          = 250_000_000;
    localparam longint      gate_100ms_ms   = 100;
    localparam longint      gate_100ms_cyc  = clk_hz * gate_100ms_ms / 1000;
    localparam int          gate_decades    = 10;
endpackage

// ===== uic_sync.sv
// Two flip-flop synchroniser with edge detection on the settled level
// Assumes an asynchronous pin input
`timescale 1ns/1ns
`default_nettype none
module uic_sync
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Pin
    input  wire logic pin,
    // Settled level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic settled;
    logic prev;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta    <= 1'b0;
            settled <= 1'b0;
            prev    <= 1'b0;
        end
        else
        begin
            meta    <= pin;
            settled <= meta;
            prev    <= settled;
        end
    end

    assign level = settled;
    assign rise  = settled & ~prev;
    assign fall  = ~settled & prev;
endmodule // uic_sync
`default_nettype wire

// ===== uic_gate_timer.sv
// Gate time base: one-cycle pulse at the end of every gate window
// Assumes 100 ms tick count as parameter; 1 s and 10 s built by decade counting
`timescale 1ns/1ns
`default_nettype none
module uic_gate_timer
#(
    parameter longint TICK_CYCLES = uic_pkg::gate_100ms_cyc
)
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] gate_sel,
    // Window end
    output logic            gate_end
);
    logic [31:0] tick_cnt;
    logic [6:0]  tick_num;
    logic        tick;
    logic [6:0]  ticks_needed;

    assign tick = run && (tick_cnt == 32'(TICK_CYCLES - 1));
    assign ticks_needed = (gate_sel == uic_pkg::gate_100ms) ? 7'd1 :
                          (gate_sel == uic_pkg::gate_10s) ? 7'(uic_pkg::gate_decades * uic_pkg::gate_decades) :
                          7'(uic_pkg::gate_decades);
    assign gate_end = tick && (tick_num == ticks_needed - 7'd1);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt <= 32'h0000_0000;
            tick_num <= 7'h00;
        end
        else if (!run)
        begin
            tick_cnt <= 32'h0000_0000;
            tick_num <= 7'h00;
        end
        else
        begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'd1;
            if (gate_end)
                tick_num <= 7'h00;
            else if (tick)
                tick_num <= tick_num + 7'd1;
        end
    end
endmodule // uic_gate_timer
`default_nettype wire

// ===== uic_assertions.sv
// Checker of uic_top port behaviour
// Assumes binding onto uic_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module uic_checker
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins
    input wire logic        in_pin,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    sequence rd_acc(logic [7:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    // Mask cleared in byte 0 must silence irq on the next cycle
    sequence mask_off;
        avs_write && avs_address == 8'h1c && avs_byteenable[0] && avs_writedata[2:0] == 3'h0;
    endsequence
    AST_NO_WAIT: assert property (avs_write |-> !avs_waitrequest)
        else $error("write made to wait");
    AST_RD_ONE_WAIT: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read waited more than one cycle");
    AST_RESET_QUIET: assert property ($rose(nrst) |-> !irq && avs_readdata == 32'h0000_0000)
        else $error("irq or readdata set at reset release");
    AST_INFO_A: assert property (rd_acc(8'h20) |-> avs_readdata == 32'h0000_0110)
        else $error("info word a wrong");
    AST_INFO_B: assert property (rd_acc(8'h24) |-> avs_readdata[15:8] == 8'h03)
        else $error("info word b wrong");
    AST_INFO_C: assert property (rd_acc(8'h28) |-> avs_readdata == 32'h0000_0000)
        else $error("info word c wrong");
    AST_COUNT_24: assert property (rd_acc(8'h0c) |-> avs_readdata[31:24] == 8'h00)
        else $error("count wider than 24 bits");
    AST_MEASURE_24: assert property (rd_acc(8'h10) |-> avs_readdata[31:24] == 8'h00)
        else $error("measure wider than 24 bits");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h30 |->
        avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("readdata moved without read");
    AST_IRQ_MASKED: assert property (mask_off |=> !irq ##1 !irq)
        else $error("irq high while masked");
endmodule // uic_checker
bind uic_top uic_checker i_chk (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_pin(in_pin), .irq(irq));
`default_nettype wire

// ===== host_irq_model.sv
// Host side model: counts interrupt requests on irq
// Assumes irq is a level; a request is its rising edge
`timescale 1ns/1ns
`default_nettype none
module host_irq_model
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   nrst,
    // Interrupt line
    input  wire logic   irq,
    // Requests seen
    output logic [15:0] irq_count
);
    logic irq_q;
    ////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q     <= 1'b0;
            irq_count <= 16'h0000;
        end
        else
        begin
            irq_q <= irq;
            if (irq && !irq_q)
                irq_count <= irq_count + 16'h0001;
        end
    end
endmodule // host_irq_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench of uic_top
// Assumes uic_pkg, host_irq_model and the checker compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        in_pin = 1'b0;
    logic        irq;
    logic [15:0] irq_count;
    logic [31:0] seed = 32'h62cb_f6d1;
    logic [31:0] exp_q[$];
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    ////////////////////////////////////////
    always #2 core_clk = ~core_clk;
    // Short tick keeps gate windows cheap
    uic_top #(.TICK_CYCLES(10)) i_uic_top (.core_clk(core_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .in_pin(in_pin), .irq(irq));
    host_irq_model i_host_irq_model (.core_clk(core_clk), .nrst(nrst), .irq(irq), .irq_count(irq_count));
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read data stands at the edge where waitrequest is seen low
    always @(posedge core_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata, exp_q.pop_front());
        cycles++;
        if (cycles > 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Six cycles cover the two-stage synchroniser
    task automatic setpin(input logic v);
        @(posedge core_clk) in_pin <= v;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            setpin(1'b1);
            setpin(1'b0);
        end
    endtask
    task automatic counter(input logic [31:0] cfg, input logic [31:0] sv);
        wr(8'h00, cfg);
        wr(8'h04, sv);
        wr(8'h08, 32'h0000_0000);
        wr(8'h08, 32'h0000_0002);
        wr(8'h08, 32'h0000_0003);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h00, 32'h0000_0100);
        rd(8'h20, 32'h0000_0110);
        rd(8'h24, 32'h0000_0300);
        rd(8'h28, 32'h0000_0000);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, 32'h0000_0000);
        for (int m = 0; m < 6; m++)
        begin
            wr(8'h00, 32'h0000_0100 | m);
            rd(8'h00, 32'h0000_0100 | m);
        end
        for (int g = 0; g < 3; g++)
        begin
            wr(8'h00, (g << 8) | 3);
            rd(8'h00, (g << 8) | 3);
        end
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        wr(8'h04, seed);
        rd(8'h04, {8'h00, seed[23:0]});
        // Plain input: level readable, no event
        wr(8'h00, 32'h0000_0100);
        wr(8'h1c, 32'h0000_0003);
        pulse(1);
        rd(8'h18, 32'h0000_0000);
        setpin(1'b1);
        rd(8'h14, 32'h0000_0001);
        setpin(1'b0);
        rd(8'h14, 32'h0000_0000);
        // Edge interrupt, default rising
        wr(8'h00, 32'h0000_0101);
        pulse(2);
        rd(8'h18, 32'h0000_0001);
        rd(8'h2c, 32'h0000_0201);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({16'h0, irq_count}, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0001);
        rd(8'h2c, 32'h0000_0101);
        wr(8'h2c, 32'h0000_0001);
        rd(8'h2c, 32'h0000_0000);
        wr(8'h18, 32'h0000_0001);
        rd(8'h18, 32'h0000_0000);
        wr(8'h1c, 32'h0000_0000);
        pulse(1);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(8'h18, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0001);
        // Falling edge selected: rise ignored
        wr(8'h1c, 32'h0000_0003);
        wr(8'h00, 32'h0000_0121);
        setpin(1'b1);
        rd(8'h18, 32'h0000_0000);
        setpin(1'b0);
        rd(8'h18, 32'h0000_0001);
        wr(8'h18, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0001);
        // Up counter, interrupt at compare, stops there
        counter(32'h0000_0142, 32'h0000_0003);
        pulse(2);
        rd(8'h18, 32'h0000_0000);
        pulse(2);
        rd(8'h0c, 32'h0000_0003);
        rd(8'h18, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(8'h18, 32'h0000_0002);
        wr(8'h2c, 32'h0000_0001);
        // Up counter, interrupt off, random count
        counter(32'h0000_0102, 32'h0000_0010);
        pulse(int'(seed[1:0]) + 1);
        rd(8'h0c, {30'h0, seed[1:0]} + 32'h0000_0001);
        rd(8'h18, 32'h0000_0000);
        // Down counter on falling edge, interrupt at zero
        counter(32'h0000_0172, 32'h0000_0002);
        setpin(1'b1);
        rd(8'h0c, 32'h0000_0002);
        setpin(1'b0);
        rd(8'h0c, 32'h0000_0001);
        rd(8'h18, 32'h0000_0000);
        pulse(1);
        rd(8'h0c, 32'h0000_0000);
        rd(8'h18, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        // Frequency over a 1 s gate of ten ticks; read inside the next window
        wr(8'h08, 32'h0000_0000);
        wr(8'h00, 32'h0000_0103);
        wr(8'h08, 32'h0000_0001);
        pulse(3);
        repeat (70) @(posedge core_clk);
        rd(8'h10, 32'h0000_0003);
        // Period in clocks: each pin pulse spans 14 cycles
        wr(8'h00, 32'h0000_0104);
        pulse(3);
        rd(8'h10, 32'h0000_000e);
        // Gate counter: clocks while the pin stays high, 7 per pulse
        wr(8'h00, 32'h0000_0105);
        wr(8'h08, 32'h0000_0003);
        wr(8'h08, 32'h0000_0001);
        pulse(2);
        rd(8'h0c, 32'h0000_000e);
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
